// >>> src/acs_device.sv
// Converter sequencer: reset delay, wake-up, standby, calibration, conversion.
// Assumes pins synchronous to ref_clk_i; filter output arrives as a raw word.
// Summary of operation
// - Hold logic in reset for 10 ms
// - Count 1800 wake cycles, defer commands
// - Five states; idle to standby after wake
// - Both requests high start calibration from wake or standby
// - Offset step then gain step
// - Calibration 3246 cycles, coefficients kept
// - Channel and polarity ignored in calibration
// - Calibration end: convert if request high
// - Request retoggle with calibrate restarts calibration
// - Retoggle without calibrate is ignored
// - Host never retoggles convert during calibration; the bench retoggles it, with and without calibrate
// - Calibrate pulse gives first post-calibration result
// - Bipolar adds 80000H offset
// - Same coefficients serve both polarities
// - Channel latched on convert rising edge
// - Polarity unlatched, sampled near result end
// - Host changes polarity just after ready falls
// - Continuous conversions of 1622 cycles
// - Internal logic at half clock rate
// - Standby start takes 1624 cycles
// - Convert rising edge restarts conversion
// - Binary or offset binary, saturated
// - Ready high before update, low after
//
// Chosen here: the address map and strobed register access.
`timescale 1ns/10ps
`default_nettype none
module acs_device import acs_pkg::*; #(
	parameter int unsigned POR_CYCLES = POR_CYC
) (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	// Raw filter word, signed 22 bits with headroom for range checks
	input wire logic signed [21:0] filter_word_i,
	// Link
	acs_link_if.device link,
	// Status
	output logic [2:0] state_o,
	output logic cal_valid_o,
	output logic channel_o
);
	// Elaboration check on the reset delay
	if (POR_CYCLES < 1) begin : g_por_check
		$error("POR_CYCLES must be at least 1");
	end

	acs_state_t state_q;
	logic [31:0] por_cnt_q;
	logic [12:0] cnt_q;
	logic phase_q;
	logic convert_request_prev_q;
	logic pend_cal_q;
	logic pend_convert_request_q;
	logic start_wait_q;
	logic convert_request_low_seen_q;
	logic [19:0] zero_coef_q;
	logic [19:0] gain_coef_q;
	logic channel_q;
	logic rdy_n_q;
	logic [19:0] word_q;
	logic cal_valid_q;
	logic [12:0] convert_request_len_q;

	wire convert_request_rise = link.convert_request & ~convert_request_prev_q;
	wire convert_request_fall = ~link.convert_request & convert_request_prev_q;
	wire cal_cmd = link.cal_request & link.convert_request;

	// Saturate and apply polarity offset
	function automatic logic [19:0] acs_code(input logic signed [21:0] w, input logic bip,
		input logic [19:0] zc);
		logic signed [22:0] v;
		v = 23'(w) - 23'($signed({3'b000, zc})) + (bip ? 23'($signed({3'b000, BIP_OFFSET})) : 23'sh0);
		if (v > 23'($signed({3'b000, RES_MAX})))
			return RES_MAX;
		else if (v < 23'sh0)
			return RES_MIN;
		else
			return v[19:0];
	endfunction : acs_code

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			convert_request_prev_q <= 1'b0;
			phase_q <= 1'b0;
		end else begin
			convert_request_prev_q <= link.convert_request;
			phase_q <= ~phase_q;
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_q <= ACS_POR;
			por_cnt_q <= 32'h0;
			cnt_q <= 13'h0;
			pend_cal_q <= 1'b0;
			pend_convert_request_q <= 1'b0;
			start_wait_q <= 1'b0;
			convert_request_low_seen_q <= 1'b0;
			channel_q <= 1'b0;
			convert_request_len_q <= 13'(CONVERT_REQUEST_START_CYC);
		end else begin
			if (convert_request_rise && state_q != ACS_CAL)
				channel_q <= link.channel_select;
			case (state_q)
				ACS_POR: begin
					if (por_cnt_q >= POR_CYCLES - 1) begin
						state_q <= ACS_WAKE;
						cnt_q <= 13'h0;
					end else begin
						por_cnt_q <= por_cnt_q + 32'h1;
					end
				end
				ACS_WAKE: begin
					if (cal_cmd)
						pend_cal_q <= 1'b1;
					else if (convert_request_rise)
						pend_convert_request_q <= 1'b1;
					if (cnt_q >= 13'(WAKE_CYC - 1)) begin
						cnt_q <= 13'h0;
						if (pend_cal_q || cal_cmd) begin
							state_q <= ACS_CAL;
							convert_request_low_seen_q <= 1'b0;
						end else if (pend_convert_request_q || convert_request_rise) begin
							state_q <= ACS_CONVERT_REQUEST;
							start_wait_q <= phase_q;
							convert_request_len_q <= 13'(CONVERT_REQUEST_START_CYC);
						end else begin
							state_q <= ACS_STBY;
						end
						pend_cal_q <= 1'b0;
						pend_convert_request_q <= 1'b0;
					end else begin
						cnt_q <= cnt_q + 13'h1;
					end
				end
				ACS_STBY: begin
					cnt_q <= 13'h0;
					if (cal_cmd) begin
						state_q <= ACS_CAL;
						convert_request_low_seen_q <= 1'b0;
					end else if (convert_request_rise) begin
						state_q <= ACS_CONVERT_REQUEST;
						start_wait_q <= phase_q;
						convert_request_len_q <= 13'(CONVERT_REQUEST_START_CYC);
					end
				end
				ACS_CAL: begin
					if (convert_request_fall)
						convert_request_low_seen_q <= 1'b1;
					if (convert_request_rise && convert_request_low_seen_q && link.cal_request) begin
						cnt_q <= 13'h0;
						convert_request_low_seen_q <= 1'b0;
					end else if (cnt_q >= 13'(CAL_CYC - 1)) begin
						cnt_q <= 13'h0;
						if (link.convert_request) begin
							state_q <= ACS_CONVERT_REQUEST;
							start_wait_q <= 1'b0;
							convert_request_len_q <= 13'(CONVERT_REQUEST_CYC);
						end else begin
							state_q <= ACS_STBY;
						end
					end else begin
						cnt_q <= cnt_q + 13'h1;
					end
				end
				ACS_CONVERT_REQUEST: begin
					if (convert_request_rise) begin
						cnt_q <= 13'h0;
						convert_request_len_q <= 13'(CONVERT_REQUEST_CYC);
					end else if (start_wait_q) begin
						start_wait_q <= 1'b0;
					end else if (cnt_q >= convert_request_len_q - 13'h1) begin
						cnt_q <= 13'h0;
						convert_request_len_q <= 13'(CONVERT_REQUEST_CYC);
						if (!link.convert_request)
							state_q <= ACS_STBY;
					end else begin
						cnt_q <= cnt_q + 13'h1;
					end
				end
				default: begin
					state_q <= ACS_POR;
				end
			endcase
		end
	end

	// Coefficient storage, offset step then gain step
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			zero_coef_q <= COEF_RST;
			gain_coef_q <= COEF_RST;
			cal_valid_q <= 1'b0;
		end else if (state_q == ACS_CAL) begin
			if (cnt_q == 13'(CAL_OFS_CYC - 1))
				zero_coef_q <= filter_word_i[19:0];
			if (cnt_q == 13'(CAL_CYC - 1)) begin
				gain_coef_q <= filter_word_i[19:0];
				cal_valid_q <= 1'b1;
			end
		end
	end

	// Ready and output word
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rdy_n_q <= 1'b1;
			word_q <= RES_MIN;
		end else if (state_q == ACS_CONVERT_REQUEST && !convert_request_rise && !start_wait_q) begin
			if (cnt_q == convert_request_len_q - 13'(RDY_LEAD_CYC) - 13'h1)
				rdy_n_q <= 1'b1;
			if (cnt_q >= convert_request_len_q - 13'h1) begin
				// Polarity is read only here, at the end of the conversion
				word_q <= acs_code(filter_word_i, link.polarity_select, zero_coef_q);
				rdy_n_q <= 1'b0;
			end
		end
	end

	assign link.result_ready_n = rdy_n_q;
	assign link.result_word = word_q;
	assign state_o = state_q;
	assign cal_valid_o = cal_valid_q;
	assign channel_o = channel_q;
endmodule : acs_device
`default_nettype wire

// >>> src/acs_pkg.sv
// Constants and types shared by the converter sequencer and its host end.
// Assumes a single 100 MHz clock shared by both ends.
package acs_pkg;
	localparam int unsigned CLK_MHZ = 100;
	localparam int unsigned POR_MS = 10;
	localparam int unsigned POR_CYC = POR_MS * 1000 * 1000 * CLK_MHZ / 1000;
	localparam int unsigned WAKE_CYC = 1800;
	localparam int unsigned CAL_CYC = 3246;
	localparam int unsigned CAL_OFS_CYC = CAL_CYC / 2;
	localparam int unsigned CONVERT_REQUEST_CYC = 1622;
	localparam int unsigned CONVERT_REQUEST_START_CYC = 1624;
	localparam int unsigned POL_STABLE_CYC = 82;
	localparam int unsigned RDY_LEAD_CYC = 2;
	localparam int unsigned RES_W = 20;
	localparam logic [19:0] BIP_OFFSET = 20'h80000;
	localparam logic [19:0] RES_MAX = 20'hFFFFF;
	localparam logic [19:0] RES_MIN = 20'h00000;
	localparam logic [19:0] COEF_RST = 20'h00000;
	localparam logic [3:0] REG_CMD = 4'h0;
	localparam logic [3:0] REG_STATUS = 4'h1;
	localparam logic [3:0] REG_RESULT = 4'h2;
	localparam int unsigned CMD_CAL_BIT = 0;
	localparam int unsigned CMD_CONVERT_REQUEST_BIT = 1;
	localparam int unsigned CMD_CH_BIT = 2;
	localparam int unsigned CMD_POL_BIT = 3;
	localparam int unsigned ST_RDY_BIT = 0;
	localparam int unsigned ST_NEW_BIT = 1;
	typedef enum logic [2:0] {
		ACS_POR = 3'b000,
		ACS_WAKE = 3'b001,
		ACS_STBY = 3'b010,
		ACS_CAL = 3'b011,
		ACS_CONVERT_REQUEST = 3'b100
	} acs_state_t;
endpackage : acs_pkg

// >>> src/acs_link_if.sv
// Pin-level link between the host controller and the converter sequencer.
// Assumes both ends share one clock; all pins are plain levels.
`timescale 1ns/10ps
`default_nettype none
interface acs_link_if;
	logic cal_request;
	logic convert_request;
	logic channel_select;
	logic polarity_select;
	logic result_ready_n;
	logic [19:0] result_word;
	modport device (input cal_request, input convert_request, input channel_select,
		input polarity_select, output result_ready_n, output result_word);
	modport host (output cal_request, output convert_request, output channel_select,
		output polarity_select, input result_ready_n, input result_word);
endinterface : acs_link_if
`default_nettype wire

// >>> src/acs_host.sv
// Host controller end: drives request, channel and polarity pins from registers.
// Assumes software on a plain strobe port; read data one cycle after the strobe.
`timescale 1ns/10ps
`default_nettype none
module acs_host import acs_pkg::*; (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	// Software port
	input wire logic [3:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [31:0] rdata_o,
	// Link
	acs_link_if.host link
);
	logic cal_q;
	logic convert_request_q;
	logic ch_q;
	logic pol_q;
	logic rdy_prev_q;
	logic new_q;
	logic [19:0] res_q;
	logic [31:0] rdata_q;

	wire rdy_fall = rdy_prev_q & ~link.result_ready_n;
	wire st_rd = rd_i && addr_i == REG_STATUS;

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cal_q <= 1'b0;
			convert_request_q <= 1'b0;
			ch_q <= 1'b0;
			pol_q <= 1'b0;
		end else if (wr_i && addr_i == REG_CMD) begin
			// Software must raise both requests together and not retoggle convert during calibration; the bench retoggles it in sc_recal
			cal_q <= wdata_i[CMD_CAL_BIT];
			convert_request_q <= wdata_i[CMD_CONVERT_REQUEST_BIT];
			if (!cal_q)
				ch_q <= wdata_i[CMD_CH_BIT];
			pol_q <= wdata_i[CMD_POL_BIT];
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rdy_prev_q <= 1'b1;
			new_q <= 1'b0;
			res_q <= RES_MIN;
		end else begin
			rdy_prev_q <= link.result_ready_n;
			if (rdy_fall) begin
				res_q <= link.result_word;
				new_q <= 1'b1;
			end else if (st_rd) begin
				new_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rdata_q <= 32'h0;
		end else if (rd_i) begin
			case (addr_i)
				REG_CMD: rdata_q <= {28'h0, pol_q, ch_q, convert_request_q, cal_q};
				REG_STATUS: rdata_q <= {30'h0, new_q | rdy_fall, link.result_ready_n};
				REG_RESULT: rdata_q <= {12'h0, res_q};
				default: rdata_q <= 32'h0;
			endcase
		end else begin
			rdata_q <= 32'h0;
		end
	end

	assign rdata_o = rdata_q;
	assign link.cal_request = cal_q;
	assign link.convert_request = convert_request_q;
	assign link.channel_select = ch_q;
	assign link.polarity_select = pol_q;
endmodule : acs_host
`default_nettype wire

// >>> tb/acs_link_properties.sv
// Link pin checks for the converter sequencer.
// Assumes one clock; pins sampled on its rising edge.
`timescale 1ns/10ps
`default_nettype none
module acs_link_properties import acs_pkg::*; #(
	parameter int unsigned POR_CYCLES = 4
) (
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	input wire logic cal_request,
	input wire logic convert_request,
	input wire logic result_ready_n,
	input wire logic [19:0] result_word
);
	logic convert_request_q, both_q, rdy_q, idle_q, quiet_q, cal_q;
	int unsigned rise_n_q, fall_n_q, cal_n_q, rst_n_q;
	wire logic rise = convert_request & !convert_request_q;
	wire logic both = cal_request & convert_request & !both_q;
	wire logic fall = rdy_q & !result_ready_n;
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			convert_request_q <= 1'b0;
			both_q <= 1'b0;
			rdy_q <= 1'b1;
			rise_n_q <= 0;
			fall_n_q <= 0;
			cal_n_q <= 0;
			rst_n_q <= 0;
		end else begin
			convert_request_q <= convert_request;
			both_q <= cal_request & convert_request;
			rdy_q <= result_ready_n;
			rise_n_q <= rise ? 1 : rise_n_q + 1;
			fall_n_q <= fall ? 1 : fall_n_q + 1;
			cal_n_q <= both ? 1 : cal_n_q + 1;
			rst_n_q <= rst_n_q + 1;
		end
	end
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			idle_q <= 1'b0;
			quiet_q <= 1'b0;
			cal_q <= 1'b0;
		end else begin
			idle_q <= !rise & (idle_q | (fall & !convert_request));
			quiet_q <= !rise & convert_request & !cal_request & (quiet_q | fall);
			cal_q <= both | (cal_q & !fall);
		end
	end
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n_i);
	sequence lead_s;
		result_ready_n [*2] ##1 !result_ready_n;
	endsequence
	a_ready_lead: assert property ($rose(result_ready_n) |-> lead_s) else $error("ready lead wrong");
	a_word_on_fall: assert property ($changed(result_word) |-> $fell(result_ready_n)) else $error("word moved");
	a_ready_hold: assert property ($fell(result_ready_n) |=> !result_ready_n [*8]) else $error("ready short");
	a_convert_request_min: assert property (fall |-> rise_n_q >= CONVERT_REQUEST_CYC) else $error("result too early");
	a_cal_span: assert property (fall && cal_q |-> cal_n_q >= CAL_CYC + CONVERT_REQUEST_CYC) else $error("cal short");
	a_convert_request_period: assert property (fall && quiet_q |-> fall_n_q == CONVERT_REQUEST_CYC) else $error("period wrong");
	a_idle_quiet: assert property (fall |-> !idle_q) else $error("result while idle");
	a_wake_defer: assert property (fall |-> rst_n_q >= POR_CYCLES + WAKE_CYC + CONVERT_REQUEST_CYC) else $error("wake");
endmodule : acs_link_properties
`default_nettype wire

// >>> tb/adc_cal_convert_sequencer_bench.sv
// Bench joining host end and sequencer over the link.
// Assumes software port with read data one cycle after strobe.
`timescale 1ns/10ps
`default_nettype none
module adc_cal_convert_sequencer_bench import acs_pkg::*; ();
	logic ref_clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic [3:0] addr_i = 4'h0;
	logic [31:0] wdata_i = 32'h0;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic signed [21:0] filt = 22'sh000100;
	logic [31:0] rdata_o;
	logic [2:0] state_o;
	logic cal_valid_o;
	logic channel_o;
	int bad_count = 0;
	int comparisons = 0;
	int cyc = 0;
	int cal_cyc = 0;
	acs_link_if link ();
	acs_device #(.POR_CYCLES(4)) acs_device_i (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .filter_word_i(filt),
		.link(link), .state_o(state_o), .cal_valid_o(cal_valid_o), .channel_o(channel_o));
	acs_host acs_host_i (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .link(link));
	acs_link_properties #(.POR_CYCLES(4)) acs_link_properties_i (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
		.cal_request(link.cal_request), .convert_request(link.convert_request),
		.result_ready_n(link.result_ready_n), .result_word(link.result_word));
	initial begin
		forever #5 ref_clk_i = ~ref_clk_i;
	end
	always @(posedge ref_clk_i) begin
		cyc++;
		if (state_o === ACS_CAL) begin
			cal_cyc++;
		end
		if (cyc == 40000) begin
			bad_count++;
			end_sim();
		end
	end
	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : end_sim
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected %s expected %0h seen %0h", what, exp, got);
		end
	endtask : chk
	task automatic wr(input logic [31:0] d);
		@(posedge ref_clk_i);
		addr_i <= REG_CMD;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge ref_clk_i);
		wr_i <= 1'b0;
		#1;
	endtask : wr
	task automatic rd(input logic [3:0] a, input logic [31:0] exp);
		@(posedge ref_clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge ref_clk_i);
		rd_i <= 1'b0;
		#1;
		chk("read data", exp, rdata_o);
	endtask : rd
	task automatic wait_fall(output int n);
		logic p;
		n = 0;
		p = 1'b0;
		while (n < 6000 && !(p === 1'b1 && link.result_ready_n === 1'b0)) begin
			p = link.result_ready_n;
			@(posedge ref_clk_i);
			#1;
			n++;
		end
		if (n >= 6000) begin
			bad_count++;
			$display("unexpected ready fall expected within 6000 cycles seen %0d", n);
		end
	endtask : wait_fall
	task automatic sc_cal();
		int n;
		wr(32'h3);
		repeat (4) @(posedge ref_clk_i);
		#1;
		chk("state in wake", ACS_WAKE, state_o);
		chk("cal valid early", 1'b0, cal_valid_o);
		while (state_o !== ACS_CAL && cyc < 3000) @(posedge ref_clk_i);
		wr(32'h2);
		rd(REG_CMD, 32'h2);
		wait_fall(n);
		chk("cal cycles", CAL_CYC, cal_cyc);
		chk("cal valid", 1'b1, cal_valid_o);
		chk("state after cal", ACS_CONVERT_REQUEST, state_o);
		rd(REG_RESULT, 32'h0);
		rd(REG_STATUS, 32'h2);
		rd(REG_STATUS, 32'h0);
	endtask : sc_cal
	task automatic sc_codes();
		logic [21:0] tf [5] = '{22'h000223, 22'h000223, 22'h180000, 22'h3FFFF0, 22'h000000};
		logic [31:0] pol [5] = '{32'h2, 32'hA, 32'h2, 32'h2, 32'hA};
		logic [31:0] ex [5] = '{32'h00123, 32'h80123, 32'hFFFFF, 32'h0, 32'h7FF00};
		int n;
		for (int i = 0; i < 5; i++) begin
			@(posedge ref_clk_i);
			filt <= tf[i];
			wr(pol[i]);
			wait_fall(n);
			rd(REG_RESULT, ex[i]);
		end
	endtask : sc_codes
	task automatic sc_stby();
		int n;
		wr(32'h0);
		while (state_o !== ACS_STBY && cyc < 30000) @(posedge ref_clk_i);
		chk("standby", ACS_STBY, state_o);
		wr(32'h6);
		wait_fall(n);
		chk("standby start", 1, n >= 1624 && n <= 1628);
		chk("channel", 1'b1, channel_o);
		wr(32'h4);
		wr(32'h2);
		wait_fall(n);
		chk("restart", 1, n >= 1622 && n <= 1628);
		wr(32'h6);
		chk("channel held", 1'b0, channel_o);
		wr(32'h0);
		rd(4'hF, 32'h0);
	endtask : sc_stby
	task automatic sc_recal();
		int c0;
		while (state_o !== ACS_STBY && cyc < 39000) @(posedge ref_clk_i);
		wr(32'h3);
		@(posedge ref_clk_i);
		#1;
		chk("cal from standby", ACS_CAL, state_o);
		wr(32'h1);
		wr(32'h3);
		// Restart is seen one edge after the request register moves
		c0 = cal_cyc;
		wr(32'h0);
		wr(32'h2);
		wr(32'h0);
		while (state_o !== ACS_STBY && cyc < 39000) @(posedge ref_clk_i);
		#1;
		chk("recal cycles", CAL_CYC + 1, cal_cyc - c0);
		chk("state after recal", ACS_STBY, state_o);
	endtask : sc_recal
	initial begin
		repeat (20) @(posedge ref_clk_i);
		rst_n_i <= 1'b1;
		sc_cal();
		sc_codes();
		sc_stby();
		sc_recal();
		end_sim();
	end
endmodule : adc_cal_convert_sequencer_bench
`default_nettype wire
